/* File: hw/rotate_core.v */
`timescale 1ns/1ps
`include "rotate_unit_regs.vh"
module rotate_core (
  input wire [63:0] operand,
  input wire [1:0] size_code,
  input wire [5:0] amount,
  input wire dir_right,
  output reg [63:0] result
);
  reg [5:0] amt_left;
  reg [63:0] d8;
  reg [63:0] d16;
  reg [63:0] d32;
  reg [127:0] d64;
  always @* begin
    amt_left = dir_right ? (6'h0 - amount) : amount;
    d8 = {48'h0, operand[7:0], operand[7:0]} << amt_left[2:0];
    d16 = {32'h0, operand[15:0], operand[15:0]} << amt_left[3:0];
    d32 = {operand[31:0], operand[31:0]} << amt_left[4:0];
    d64 = {operand, operand} << amt_left;
    case (size_code)
      `SIZE_8: result = {56'h0, d8[15:8]};
      `SIZE_16: result = {48'h0, d16[31:16]};
      `SIZE_32: result = {32'h0, d32[63:32]};
      default: result = d64[127:64];
    endcase
  end
endmodule // rotate_core

/* File: hw/rotate_left_right_unit.v */
`timescale 1ns/1ps
`include "rotate_unit_regs.vh"
// Function
// RULE1 - D3 /0 at 16-bit size rotates left by count_reg_low_byte.
// RULE2 - C1 /0 at 16-bit size rotates left by immediate_count_byte.
// RULE3 - D1 /0 at 32-bit size rotates left by exactly one.
// RULE4 - D3 /0 at 32-bit size rotates left by count_reg_low_byte.
// RULE5 - C1 /0 at 32-bit size rotates left by immediate_count_byte.
// RULE6 - D1 /0 at 64-bit size rotates left by one.
// RULE7 - D3 /0 at 64-bit size rotates left by count_reg_low_byte.
// RULE8 - C1 /0 at 64-bit size rotates left by immediate_count_byte.
// RULE9 - D0 /0 rotates 8-bit operand right by one.
// RULE10 - 8-bit right rotate form by count_reg_low_byte is supported.
// RULE11 - Operand size from size prefix and 64-bit prefix picks variant.
// RULE12 - Count is reduced modulo operand width before rotating.
module rotate_left_right_unit (
  input wire clk,
  input wire rst,
  input wire issue_valid,
  input wire [7:0] opcode,
  input wire [2:0] modrm_reg,
  input wire size_prefix,
  input wire wide_prefix,
  input wire [63:0] operand,
  input wire [7:0] count_reg_low_byte,
  input wire [7:0] immediate_count_byte,
  output reg result_valid,
  output reg [63:0] result,
  output reg [1:0] result_size,
  output reg illegal
);
  // ----------------------------------------
  // Opcode form decode
  // ----------------------------------------
  wire op_byte_one;
  wire op_byte_count;
  wire op_byte_imm;
  wire op_word_one;
  wire op_word_count;
  wire op_word_imm;
  wire form_byte;
  wire form_word;
  wire form_one;
  wire form_count;
  wire form_imm;
  wire reg_left;
  wire reg_right;

  assign op_byte_one = (opcode == `OPC_ROT8_ONE);
  assign op_byte_count = (opcode == `OPC_ROT8_CNT);
  assign op_byte_imm = (opcode == `OPC_ROT8_IMM);
  assign op_word_one = (opcode == `OPC_ROT_ONE);
  assign op_word_count = (opcode == `OPC_ROT_CNT);
  assign op_word_imm = (opcode == `OPC_ROT_IMM);
  assign form_byte = op_byte_one | op_byte_count | op_byte_imm;
  assign form_word = op_word_one | op_word_count | op_word_imm;
  assign form_one = op_byte_one | op_word_one;
  assign form_count = op_byte_count | op_word_count;
  assign form_imm = op_byte_imm | op_word_imm;
  assign reg_left = (modrm_reg == `REG_ROTATE_LEFT);
  assign reg_right = (modrm_reg == `REG_ROTATE_RIGHT);

  // ----------------------------------------
  // Effective operand size
  // ----------------------------------------
  wire size_is_8;
  wire size_is_16;
  wire size_is_32;
  wire size_is_64;
  reg [1:0] size_code;
  assign size_is_8 = form_byte;
  assign size_is_64 = ~form_byte & wide_prefix; // RULE11
  assign size_is_16 = ~form_byte & ~wide_prefix & size_prefix; // RULE11
  assign size_is_32 = ~form_byte & ~wide_prefix & ~size_prefix; // RULE11
  always @* begin
    if (size_is_8) begin
      size_code = `SIZE_8;
    end else if (size_is_16) begin
      size_code = `SIZE_16;
    end else if (size_is_32) begin
      size_code = `SIZE_32;
    end else begin
      size_code = `SIZE_64;
    end
  end

  // ----------------------------------------
  // Documented forms
  // ----------------------------------------
  wire hit_rule1;
  wire hit_rule2;
  wire hit_rule3;
  wire hit_rule4;
  wire hit_rule5;
  wire hit_rule6;
  wire hit_rule7;
  wire hit_rule8;
  wire hit_rule9;
  wire hit_rule10;
  wire hit_word16_one;
  wire hit_byte_imm;

  assign hit_rule1 = op_word_count & reg_left & size_is_16; // RULE1
  assign hit_rule2 = op_word_imm & reg_left & size_is_16; // RULE2
  assign hit_rule3 = op_word_one & reg_left & size_is_32; // RULE3
  assign hit_rule4 = op_word_count & reg_left & size_is_32; // RULE4
  assign hit_rule5 = op_word_imm & reg_left & size_is_32; // RULE5
  assign hit_rule6 = op_word_one & reg_left & size_is_64; // RULE6
  assign hit_rule7 = op_word_count & reg_left & size_is_64; // RULE7
  assign hit_rule8 = op_word_imm & reg_left & size_is_64; // RULE8
  assign hit_rule9 = op_byte_one & reg_left; // RULE9
  assign hit_rule10 = op_byte_count & reg_left; // RULE10
  assign hit_word16_one = op_word_one & reg_left & size_is_16;
  assign hit_byte_imm = op_byte_imm & reg_left;

  // ----------------------------------------
  // Direction select
  // ----------------------------------------
  wire rotate_left_sel;
  wire rotate_right_sel;
  wire form_legal;
  wire dir_right;
  // Byte forms with a zero reg field turn right
  assign rotate_right_sel = hit_rule9 | hit_rule10 | hit_byte_imm | (form_word & reg_right);
  assign rotate_left_sel = hit_rule1 | hit_rule2 | hit_rule3 | hit_rule4 | hit_rule5 |
                           hit_rule6 | hit_rule7 | hit_rule8 | hit_word16_one |
                           (form_byte & reg_right);
  assign form_legal = rotate_left_sel | rotate_right_sel;
  assign dir_right = rotate_right_sel;

  // ----------------------------------------
  // Count source
  // ----------------------------------------
  reg [7:0] raw_count;
  always @* begin
    if (form_one) begin
      raw_count = 8'h01; // RULE3 RULE6 RULE9
    end else if (form_count) begin
      raw_count = count_reg_low_byte; // RULE1 RULE4 RULE7 RULE10
    end else if (form_imm) begin
      raw_count = immediate_count_byte; // RULE2 RULE5 RULE8
    end else begin
      raw_count = 8'h00;
    end
  end

  // ----------------------------------------
  // Count reduction
  // ----------------------------------------
  reg [5:0] amount;
  always @* begin
    case (size_code)
      `SIZE_8: amount = {3'h0, raw_count[2:0]}; // RULE12
      `SIZE_16: amount = {2'h0, raw_count[3:0]}; // RULE12
      `SIZE_32: amount = {1'h0, raw_count[4:0]}; // RULE12
      default: amount = raw_count[5:0]; // RULE12
    endcase
  end

  // ----------------------------------------
  // Rotator
  // ----------------------------------------
  wire [63:0] rotated;
  rotate_core u_core (
    .operand(operand),
    .size_code(size_code),
    .amount(amount),
    .dir_right(dir_right),
    .result(rotated)
  );

  // ----------------------------------------
  // Width mask
  // ----------------------------------------
  wire [63:0] width_mask;
  genvar bit_idx;
  generate
    for (bit_idx = 0; bit_idx < 64; bit_idx = bit_idx + 1) begin : g_mask
      if (bit_idx < 8) begin : g_w8
        assign width_mask[bit_idx] = 1'b1;
      end else if (bit_idx < 16) begin : g_w16
        assign width_mask[bit_idx] = ~size_is_8;
      end else if (bit_idx < 32) begin : g_w32
        assign width_mask[bit_idx] = size_is_32 | size_is_64;
      end else begin : g_w64
        assign width_mask[bit_idx] = size_is_64;
      end
    end
  endgenerate

  // ----------------------------------------
  // Illegal detect
  // ----------------------------------------
  wire illegal_next;
  assign illegal_next = issue_valid & ~form_legal;

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      result_valid <= 1'b0;
    end else begin
      result_valid <= issue_valid;
    end
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      illegal <= 1'b0;
    end else begin
      illegal <= illegal_next;
    end
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      result <= `RESULT_RESET;
    end else if (issue_valid) begin
      result <= rotated & width_mask; // RULE1 RULE2 RULE3 RULE4 RULE5 RULE6 RULE7 RULE8
    end
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      result_size <= `SIZE_8;
    end else if (issue_valid) begin
      result_size <= size_code; // RULE11
    end
  end
endmodule // rotate_left_right_unit

/* File: hw/rotate_unit_regs.vh */
`ifndef ROTATE_UNIT_REGS_VH
`define ROTATE_UNIT_REGS_VH
// ----------------------------------------
// Opcode bytes
// ----------------------------------------
`define OPC_ROT8_ONE 8'hd0
`define OPC_ROT_ONE 8'hd1
`define OPC_ROT8_CNT 8'hd2
`define OPC_ROT_CNT 8'hd3
`define OPC_ROT8_IMM 8'hc0
`define OPC_ROT_IMM 8'hc1
// ----------------------------------------
// Operation encodings (ModRM reg field)
// ----------------------------------------
`define REG_ROTATE_LEFT 3'h0
`define REG_ROTATE_RIGHT 3'h1
// ----------------------------------------
// Operand size codes
// ----------------------------------------
`define SIZE_8 2'h0
`define SIZE_16 2'h1
`define SIZE_32 2'h2
`define SIZE_64 2'h3
// ----------------------------------------
// Latency and reset values
// ----------------------------------------
`define EXEC_LATENCY_CYCLES 1
`define RESULT_RESET 64'h0000000000000000
`endif

/* File: tb/rotate_unit_sva.sv */
`timescale 1ns/1ps
module rotate_unit_sva (
  input wire clk,
  input wire rst,
  input wire issue_valid,
  input wire [7:0] opcode,
  input wire [2:0] modrm_reg,
  input wire [63:0] operand,
  input wire result_valid,
  input wire [63:0] result,
  input wire [1:0] result_size
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_go(o); issue_valid && modrm_reg == 3'h0 && opcode == o; endsequence
  property p_vld; issue_valid |=> result_valid; endproperty
  a_vld: assert property (p_vld) else $error("no result");
  property p_idle; !issue_valid |=> !result_valid && $stable(result); endproperty
  a_idle: assert property (p_idle) else $error("spurious result");
  property p_d1; s_go(8'hd1) ##1 result_size == 2'h2
    |-> result[31:0] == {$past(operand[30:0]), $past(operand[31])}; endproperty
  a_d1: assert property (p_d1) else $error("bad rotate 32");
  property p_d64; s_go(8'hd1) ##1 result_size == 2'h3
    |-> result == {$past(operand[62:0]), $past(operand[63])}; endproperty
  a_d64: assert property (p_d64) else $error("bad rotate 64");
  property p_d0; s_go(8'hd0)
    |=> result[7:0] == {$past(operand[0]), $past(operand[7:1])}; endproperty
  a_d0: assert property (p_d0) else $error("bad rotate 8");
  property p_sz; s_go(8'hd2) |=> result_size == 2'h0; endproperty
  a_sz: assert property (p_sz) else $error("bad size");
  property p_z8; result_valid && result_size == 2'h0 |-> result[63:8] == 56'h0; endproperty
  a_z8: assert property (p_z8) else $error("not extended");
  property p_z16; result_valid && result_size == 2'h1 |-> result[63:16] == 48'h0; endproperty
  a_z16: assert property (p_z16) else $error("not extended");
endmodule // rotate_unit_sva
bind rotate_left_right_unit rotate_unit_sva chk (.clk, .rst, .issue_valid, .opcode,
  .modrm_reg, .operand, .result_valid, .result, .result_size);

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
  logic clk = 0, rst = 1, iv = 0, sp = 0, wp = 0, rv, il, s, v, k;
  logic [7:0] opc = 0, cl = 0, im = 0, a, c, j, t;
  logic [2:0] rg = 0, g;
  logic [63:0] op = 0, res, x, y, m;
  logic [1:0] rs, sz;
  logic [66:0] q[$], e;
  logic [7:0] ot[7] = '{8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hc0, 8'hc1, 8'h90};
  int n_fail = 0, checks = 0, i, w, n;
  always #5 clk = ~clk;
  rotate_left_right_unit DUT (.clk(clk), .rst(rst), .issue_valid(iv), .opcode(opc),
    .modrm_reg(rg), .size_prefix(sp), .wide_prefix(wp), .operand(op),
    .count_reg_low_byte(cl), .immediate_count_byte(im), .result_valid(rv),
    .result(res), .result_size(rs), .illegal(il));
  task results;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) if (rv === 1'b1) begin
    checks++;
    e = q.pop_front();
    if (il !== e[66] || (!e[66] && {rs, res} !== e[65:0])) begin
      n_fail++;
      $display("mismatch %0t wrong result, expected %h", $time, e);
    end
  end
  initial begin
    void'($urandom(94));
    repeat (20) @(posedge clk);
    rst <= 0;
    for (i = 0; i < 3000; i++) begin
      @(posedge clk);
      t = ot[$urandom % 7];
      g = $urandom % 4 == 3 ? 3'h6 : (t[0] ? 3'($urandom % 2) : 3'h0);
      {s, v, c, j, k} = 19'($urandom);
      y = {$urandom, $urandom};
      w = !t[0] ? 8 : v ? 64 : s ? 16 : 32;
      sz = !t[0] ? 2'h0 : v ? 2'h3 : s ? 2'h1 : 2'h2;
      a = t[1] ? c : t[4] ? 8'h1 : j;
      n = a % w;
      if (!t[0] || g == 3'h1) n = (w - n) % w;
      m = w == 64 ? '1 : (64'h1 << w) - 1;
      x = y & m;
      {opc, rg, sp, wp, op, cl, im, iv} <= {t, g, s, v, y, c, j, k};
      if (k) q.push_back({t == 8'h90 || g > 3'h1, sz, ((x << n) | (x >> (w - n))) & m});
    end
    @(posedge clk);
    iv <= 0;
    repeat (3) @(posedge clk);
    if (q.size() != 0) begin
      n_fail++;
      $display("mismatch %0t results missing", $time);
    end
    $display("random rotate test done");
    results;
  end
endmodule // tb
